//--- rtl/secset_pkg.sv
// Constants, types and helpers for the security-setting exchange host.
// Assumes a 10 MHz reference clock; every time is given in nanoseconds.
package secset_pkg;

  // Clock period of ref_clk_i.
  localparam longint CLK_PERIOD_NS = 64'd100;

  // Documented times, as printed.
  localparam longint COMMAND_WAIT_NS = 64'd595_000;
  localparam longint DATA_FRAME_WAIT_B_NS = 64'd120_000;
  localparam longint DATA_STATUS_MAX_NS = 64'd20_000;
  localparam longint DATA_STATUS_SLACK_NS = 64'd100_000;
  localparam longint WRITE_STATUS_TIMEOUT_NS = 64'd843_700_000;
  localparam longint OPEN_TIMEOUT_NS = 64'd3_000_000_000;

  // A least time rounds up to whole cycles.
  function automatic logic [31:0] cyc_min(input longint t_ns);
    longint c;
    c = (t_ns + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
    if (c < 64'd1) c = 64'd1;
    return c[31:0];
  endfunction

  // A longest time rounds down, never below one cycle.
  function automatic logic [31:0] cyc_max(input longint t_ns);
    longint c;
    c = t_ns / CLK_PERIOD_NS;
    if (c < 64'd1) c = 64'd1;
    return c[31:0];
  endfunction

  localparam logic [31:0] COMMAND_WAIT_CYC = cyc_min(COMMAND_WAIT_NS);
  localparam logic [31:0] DATA_WAIT_CYC = cyc_min(DATA_FRAME_WAIT_B_NS);
  localparam logic [31:0] DATA_STATUS_CYC =
    cyc_max(DATA_STATUS_MAX_NS + DATA_STATUS_SLACK_NS);
  localparam logic [31:0] WRITE_STATUS_CYC = cyc_max(WRITE_STATUS_TIMEOUT_NS);
  localparam logic [31:0] OPEN_TIMEOUT_CYC = cyc_min(OPEN_TIMEOUT_NS);

  // Status codes carried in the first status byte.
  localparam logic [7:0] ST_ACK = 8'h06;
  localparam logic [7:0] ST_PARAM_ERR = 8'h05;
  localparam logic [7:0] ST_SUM_ERR = 8'h07;
  localparam logic [7:0] ST_PROTECT_ERR = 8'h10;
  localparam logic [7:0] ST_NACK = 8'h15;
  localparam logic [7:0] ST_MARGIN_ONE_ERR = 8'h1A;
  localparam logic [7:0] ST_MARGIN_TWO_ERR = 8'h1B;
  localparam logic [7:0] ST_WRITE_ERR = 8'h1C;

  // Frame contents.
  localparam logic [7:0] FLAG_FORCE_MASK = 8'hE8;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] CMD_PARAM_COUNT = 3'h3;
  localparam logic [2:0] DATA_PAYLOAD_COUNT = 3'h6;
  localparam logic [7:0] DEFAULT_SECSET_CMD = 8'hA0;

  // Outcome of one transaction.
  typedef enum logic [2:0] {
    RES_NONE,
    RES_NORMAL,
    RES_CMD_ABNORMAL,
    RES_TIMEOUT,
    RES_DATA_ABNORMAL,
    RES_WRITE_ABNORMAL
  } result_e;

  // Frame handed to the framing layer; payload byte 0 goes first.
  typedef struct packed {
    logic is_data;
    logic [7:0] cmd;
    logic [2:0] count;
    logic [5:0][7:0] payload;
  } tx_frame_s;

  // Status frame as delivered by the framing layer.
  typedef struct packed {
    logic frame_ok;
    logic [7:0] first_status_byte;
  } rx_status_s;

  function automatic logic is_ack(input rx_status_s s);
    return s.first_status_byte == ST_ACK;
  endfunction

endpackage

//--- rtl/wait_timer.sv
// One-shot down counter used for frame spacing and status time-outs.
// Assumes a synchronous active-low reset and a loaded count of one or more.
`timescale 1ns/1ps
module wait_timer import secset_pkg::*; #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input logic ref_clk_i,
  input logic rst_n_i,
  // Control.
  input logic load_i,
  input logic stop_i,
  input logic [WIDTH-1:0] count_i,
  // Status.
  output logic expired_o
);

  logic [WIDTH-1:0] cnt_r;
  logic armed_r;
  wire at_zero = (cnt_r == '0);

  // Expiry is a level that holds until the next load or stop.
  assign expired_o = armed_r && at_zero;

  // A load restarts the count even while a previous one is running.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      armed_r <= 1'b0;
    end else if (load_i) begin
      cnt_r <= count_i - WIDTH'(1);
      armed_r <= 1'b1;
    end else if (stop_i) begin
      armed_r <= 1'b0;
    end else if (!at_zero) begin
      cnt_r <= cnt_r - WIDTH'(1);
    end
  end

endmodule

//--- rtl/security_set_host.sv
// Host-side sequencer for the security-setting command exchange.
// Assumes a framing layer that serialises tx frames, checks received
// frames and reports each status frame with a one-cycle rx_valid_i.
`timescale 1ns/1ps
module security_set_host import secset_pkg::*; #(
  parameter logic [7:0] SECSET_CMD = DEFAULT_SECSET_CMD,
  parameter int CMD_WAIT_CYCLES = COMMAND_WAIT_CYC,
  parameter int CMD_STATUS_CYCLES = OPEN_TIMEOUT_CYC,
  parameter int WRITE_STATUS_CYCLES = WRITE_STATUS_CYC
) (
  // Clock and reset.
  input logic ref_clk_i,
  input logic rst_n_i,
  // User orders.
  input logic start_i,
  input logic [7:0] security_flag_byte_i,
  input logic [7:0] boot_block_i,
  input logic [7:0] swap_start_i,
  input logic [7:0] swap_end_i,
  // User answers.
  output logic busy_o,
  output logic done_o,
  output result_e result_o,
  output logic [7:0] status_code_o,
  // Frame transmit side.
  output logic tx_valid_o,
  output tx_frame_s tx_frame_o,
  input logic tx_ready_i,
  input logic tx_done_i,
  // Frame receive side.
  output logic rx_enable_o,
  input logic rx_valid_i,
  input rx_status_s rx_status_i
);

  typedef enum logic [3:0] {
    S_IDLE,
    S_CMD_GAP,
    S_CMD_SEND,
    S_CMD_STAT,
    S_DATA_GAP,
    S_DATA_SEND,
    S_DATA_STAT,
    S_WR_STAT
  } state_e;

  state_e state_r, state_nxt;
  logic [31:0] gap_r;
  logic tmr_load, tmr_expired;
  logic [31:0] tmr_count;
  tx_frame_s cmd_frame, data_frame;
  logic [7:0] param_r [3];
  logic [5:0][7:0] data_r;

  // A status frame only counts when the framing checks passed.
  wire rx_good = rx_valid_i && rx_status_i.frame_ok;
  wire rx_ack = rx_good && is_ack(rx_status_i);
  wire gap_met = gap_r >= 32'(CMD_WAIT_CYCLES);
  wire tx_taken = tx_valid_o && tx_ready_i;

  // Frame images; the user bytes are caught at start_i so they stay put.
  assign cmd_frame.is_data = 1'b0;
  assign cmd_frame.cmd = SECSET_CMD;
  assign cmd_frame.count = CMD_PARAM_COUNT;
  assign cmd_frame.payload = {ZERO_BYTE, ZERO_BYTE, ZERO_BYTE,
                              param_r[2], param_r[1], param_r[0]};
  assign data_frame.is_data = 1'b1;
  assign data_frame.cmd = ZERO_BYTE;
  assign data_frame.count = DATA_PAYLOAD_COUNT;
  assign data_frame.payload = data_r;

  // Timer loads: data spacing on an accepted command status, time-outs
  // at the end of each transmitted frame, write time-out on data ACK.
  wire load_data_gap = (state_r == S_CMD_STAT) && rx_ack;
  wire load_cmd_to = (state_r == S_CMD_SEND) && tx_done_i;
  wire load_data_to = (state_r == S_DATA_SEND) && tx_done_i;
  wire load_wr_to = (state_r == S_DATA_STAT) && rx_ack;
  assign tmr_load = load_data_gap || load_cmd_to || load_data_to || load_wr_to;
  assign tmr_count = load_data_gap ? DATA_WAIT_CYC :
                     load_cmd_to ? 32'(CMD_STATUS_CYCLES) :
                     load_data_to ? DATA_STATUS_CYC :
                     32'(WRITE_STATUS_CYCLES);

  wait_timer #(.WIDTH(32)) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .stop_i(state_r == S_IDLE),
    .count_i(tmr_count),
    .expired_o(tmr_expired)
  );

  // Next state; a status beats an expiry that lands in the same cycle.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (start_i) state_nxt = S_CMD_GAP;
      S_CMD_GAP: if (gap_met) state_nxt = S_CMD_SEND;
      S_CMD_SEND: if (tx_done_i) state_nxt = S_CMD_STAT;
      S_CMD_STAT: begin
        if (rx_ack) state_nxt = S_DATA_GAP;
        else if (rx_good || tmr_expired) state_nxt = S_IDLE;
      end
      S_DATA_GAP: if (tmr_expired) state_nxt = S_DATA_SEND;
      S_DATA_SEND: if (tx_done_i) state_nxt = S_DATA_STAT;
      S_DATA_STAT: begin
        if (rx_ack) state_nxt = S_WR_STAT;
        else if (rx_good || tmr_expired) state_nxt = S_IDLE;
      end
      S_WR_STAT: if (rx_good || tmr_expired) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Outcome of the transaction, decided on the cycle it ends.
  wire in_wait_stat = (state_r == S_CMD_STAT) || (state_r == S_DATA_STAT) ||
                      (state_r == S_WR_STAT);
  wire finish = in_wait_stat && (state_nxt == S_IDLE);
  result_e fail_res;
  assign fail_res = (state_r == S_CMD_STAT) ? RES_CMD_ABNORMAL :
                    (state_r == S_DATA_STAT) ? RES_DATA_ABNORMAL :
                    RES_WRITE_ABNORMAL;
  result_e end_res;
  assign end_res = !rx_good ? RES_TIMEOUT :
                   rx_ack ? RES_NORMAL : fail_res;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Time since the end of the last good frame from the device. After
  // reset nothing is owed, so it starts saturated.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gap_r <= 32'hFFFF_FFFF;
    end else if (rx_good) begin
      gap_r <= 32'h0000_0000;
    end else if (gap_r != 32'hFFFF_FFFF) begin
      gap_r <= gap_r + 32'h0000_0001;
    end
  end

  // Parameter and payload capture at start.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      param_r <= '{default: ZERO_BYTE};
      data_r <= '0;
    end else if (state_r == S_IDLE && start_i) begin
      param_r[0] <= ZERO_BYTE;
      param_r[1] <= ZERO_BYTE;
      param_r[2] <= ZERO_BYTE;
      data_r[0] <= security_flag_byte_i | FLAG_FORCE_MASK;
      data_r[1] <= boot_block_i;
      data_r[2] <= ZERO_BYTE;
      data_r[3] <= swap_start_i;
      data_r[4] <= ZERO_BYTE;
      data_r[5] <= swap_end_i;
    end
  end

  // Frame requests: held until the framing layer takes them.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_frame_o <= '0;
    end else if (state_r == S_CMD_GAP && gap_met) begin
      tx_valid_o <= 1'b1;
      tx_frame_o <= cmd_frame;
    end else if (state_r == S_DATA_GAP && tmr_expired) begin
      tx_valid_o <= 1'b1;
      tx_frame_o <= data_frame;
    end else if (tx_taken) begin
      tx_valid_o <= 1'b0;
    end
  end

  // Reception opens before any frame goes out and stays open throughout.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rx_enable_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      rx_enable_o <= (state_nxt != S_IDLE);
      busy_o <= (state_nxt != S_IDLE);
    end
  end

  // User answer: a one-cycle done with a result and status that hold.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      result_o <= RES_NONE;
      status_code_o <= ZERO_BYTE;
    end else begin
      done_o <= finish;
      if (finish) begin
        result_o <= end_res;
        status_code_o <= rx_good ? rx_status_i.first_status_byte : ZERO_BYTE;
      end
    end
  end

endmodule

//--- testbench/secset_properties.sv
// Timing and framing checks on the security-setting host's ports.
// Assumes it is bound to the host and sees only the host's ports.
`timescale 1ns/1ps
module secset_properties import secset_pkg::*; #(
  parameter int CMD_WAIT_CYCLES = COMMAND_WAIT_CYC
) (
  // Clock and reset.
  input logic ref_clk_i,
  input logic rst_n_i,
  // User side.
  input logic start_i,
  input logic busy_o,
  input logic done_o,
  input result_e result_o,
  input logic [7:0] status_code_o,
  // Frame link.
  input logic tx_valid_o,
  input tx_frame_s tx_frame_o,
  input logic tx_ready_i,
  input logic rx_enable_o,
  input logic rx_valid_i,
  input rx_status_s rx_status_i
);
  logic [15:0] gap_r;

  // Cycles since the last good status; a reset counts as a long gap.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) gap_r <= 16'hFFFF;
    else if (rx_valid_i && rx_status_i.frame_ok) gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  start_busy_a:
    assert property (start_i && !busy_o |=> busy_o && rx_enable_o)
    else $error("start not taken");
  rx_before_tx_a:
    assert property (tx_valid_o |-> rx_enable_o)
    else $error("frame sent with reception off");
  tx_hold_a:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o &&
      $stable(tx_frame_o)) else $error("frame request not held");
  cmd_frame_a:
    assert property (tx_valid_o && !tx_frame_o.is_data |->
      tx_frame_o.count == CMD_PARAM_COUNT &&
      tx_frame_o.payload[2:0] == 24'h000000) else $error("bad command");
  data_frame_a:
    assert property (tx_valid_o && tx_frame_o.is_data |->
      tx_frame_o.count == DATA_PAYLOAD_COUNT &&
      (tx_frame_o.payload[0] & FLAG_FORCE_MASK) == FLAG_FORCE_MASK &&
      tx_frame_o.payload[2] == 8'h00 && tx_frame_o.payload[4] == 8'h00)
    else $error("bad data frame");
  cmd_gap_a:
    assert property ($rose(tx_valid_o) && !tx_frame_o.is_data |->
      gap_r >= CMD_WAIT_CYCLES - 1) else $error("command too early");
  data_gap_a:
    assert property ($rose(tx_valid_o) && tx_frame_o.is_data |->
      gap_r >= DATA_WAIT_CYC - 1) else $error("data frame too early");
  timeout_code_a:
    assert property (done_o && result_o == RES_TIMEOUT |->
      status_code_o == 8'h00) else $error("time-out with a code");
endmodule

//--- testbench/secset_device_model.sv
// Behavioural model of the device's programming firmware at frame level.
// Assumes the bench sets the stage codes before each transaction.
`timescale 1ns/1ps
module secset_device_model import secset_pkg::*; (
  // Clock and reset.
  input logic ref_clk_i,
  input logic rst_n_i,
  // Scenario set-up.
  input logic [7:0] cmd_code_i,
  input logic [7:0] data_code_i,
  input logic [7:0] write_code_i,
  input logic [1:0] mute_stage_i,
  input logic garble_i,
  // Frame link.
  input logic tx_valid_i,
  input tx_frame_s tx_frame_i,
  output logic tx_ready_o = 1'b0,
  output logic tx_done_o = 1'b0,
  output logic rx_valid_o = 1'b0,
  output rx_status_s rx_status_o = '0,
  output logic [47:0] data_seen_o = '0
);
  tx_frame_s fr;

  // One status after a short turnaround; junk on the line between frames.
  task automatic reply(input logic [7:0] code, input logic [1:0] stage);
    repeat (10) @(posedge ref_clk_i);
    if (mute_stage_i != stage) begin
      rx_valid_o <= 1'b1;
      rx_status_o <= {~garble_i, code};
      @(posedge ref_clk_i);
      rx_valid_o <= 1'b0;
      rx_status_o <= ~{~garble_i, code};
    end
  endtask

  // Each frame is taken one cycle late so the host must hold it.
  always begin
    @(posedge ref_clk_i);
    if (rst_n_i && tx_valid_i) begin
      tx_ready_o <= ~tx_ready_o;
      if (tx_ready_o) begin
        fr = tx_frame_i;
        repeat (3) @(posedge ref_clk_i);
        tx_done_o <= 1'b1;
        @(posedge ref_clk_i);
        tx_done_o <= 1'b0;
        if (!fr.is_data) begin
          reply(cmd_code_i, 2'd1);
        end else begin
          data_seen_o <= fr.payload;
          reply(data_code_i, 2'd2);
          // A silenced data status is not followed by a write status, so
          // the host's data time-out is what ends the transaction.
          if (data_code_i == ST_ACK && mute_stage_i != 2'd2)
            reply(write_code_i, 2'd3);
        end
      end
    end
  end
endmodule

//--- testbench/testbench.sv
// Self-checking bench: host against the device model, short time-outs.
// Assumes the host package; the clock runs at 10 MHz.
`timescale 1ns/1ps
module testbench import secset_pkg::*; ;
  typedef struct packed {
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] w;
    logic [1:0] mute;
    logic garble;
    result_e res;
    logic [7:0] code;
  } row_s;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic [7:0] flag = 8'h11;
  // Boot block differs per run, so a stale data frame cannot pass.
  logic [7:0] boot = 8'h00;
  logic [7:0] boot_val = 8'h00;
  logic [7:0] c_code = 8'h06, d_code = 8'h06, w_code = 8'h06;
  logic [1:0] mute = 2'd0;
  logic garble = 1'b0;
  logic busy_o, done_o, tx_valid_o, tx_ready, tx_done, rx_enable_o, rx_valid;
  result_e result_o;
  logic [7:0] status_code_o;
  tx_frame_s tx_frame;
  rx_status_s rx_status;
  logic [47:0] data_seen;
  int bad_count = 0;
  int n_tests = 0;
  // Stage codes, silenced stage, garbling, then expected result and code.
  row_s rows [15] = '{
    '{8'h06, 8'h06, 8'h06, 2'd0, 1'b0, RES_NORMAL, 8'h06},
    '{8'h05, 8'h06, 8'h06, 2'd0, 1'b0, RES_CMD_ABNORMAL, 8'h05},
    '{8'h07, 8'h06, 8'h06, 2'd0, 1'b0, RES_CMD_ABNORMAL, 8'h07},
    '{8'h10, 8'h06, 8'h06, 2'd0, 1'b0, RES_CMD_ABNORMAL, 8'h10},
    '{8'h15, 8'h06, 8'h06, 2'd0, 1'b0, RES_CMD_ABNORMAL, 8'h15},
    '{8'h06, 8'h1A, 8'h06, 2'd0, 1'b0, RES_DATA_ABNORMAL, 8'h1A},
    '{8'h06, 8'h1B, 8'h06, 2'd0, 1'b0, RES_DATA_ABNORMAL, 8'h1B},
    '{8'h06, 8'h1C, 8'h06, 2'd0, 1'b0, RES_DATA_ABNORMAL, 8'h1C},
    '{8'h06, 8'h06, 8'h1A, 2'd0, 1'b0, RES_WRITE_ABNORMAL, 8'h1A},
    '{8'h06, 8'h06, 8'h1B, 2'd0, 1'b0, RES_WRITE_ABNORMAL, 8'h1B},
    '{8'h06, 8'h06, 8'h1C, 2'd0, 1'b0, RES_WRITE_ABNORMAL, 8'h1C},
    '{8'h06, 8'h06, 8'h06, 2'd1, 1'b0, RES_TIMEOUT, 8'h00},
    '{8'h06, 8'h06, 8'h06, 2'd2, 1'b0, RES_TIMEOUT, 8'h00},
    '{8'h06, 8'h06, 8'h06, 2'd3, 1'b0, RES_TIMEOUT, 8'h00},
    '{8'h06, 8'h06, 8'h06, 2'd0, 1'b1, RES_TIMEOUT, 8'h00}};

  // Short time-outs keep each transaction to a few thousand cycles.
  security_set_host #(.CMD_WAIT_CYCLES(20), .CMD_STATUS_CYCLES(200),
    .WRITE_STATUS_CYCLES(200)) u_security_set_host (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .security_flag_byte_i(flag), .boot_block_i(boot),
    .swap_start_i(8'h5A), .swap_end_i(8'hA5), .busy_o(busy_o),
    .done_o(done_o), .result_o(result_o), .status_code_o(status_code_o),
    .tx_valid_o(tx_valid_o), .tx_frame_o(tx_frame), .tx_ready_i(tx_ready),
    .tx_done_i(tx_done), .rx_enable_o(rx_enable_o), .rx_valid_i(rx_valid),
    .rx_status_i(rx_status));

  secset_device_model u_secset_device_model (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_code_i(c_code),
    .data_code_i(d_code), .write_code_i(w_code), .mute_stage_i(mute),
    .garble_i(garble), .tx_valid_i(tx_valid_o), .tx_frame_i(tx_frame),
    .tx_ready_o(tx_ready), .tx_done_o(tx_done), .rx_valid_o(rx_valid),
    .rx_status_o(rx_status), .data_seen_o(data_seen));

  always #50 ref_clk_i = ~ref_clk_i;

  task automatic cmp_val(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_res(input result_e got, input result_e exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: result %0d not %0d", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A second start while busy carries other user bytes and must be ignored.
  task automatic run(input row_s r);
    @(posedge ref_clk_i);
    {c_code, d_code, w_code, mute, garble} <= {r.c, r.d, r.w, r.mute, r.garble};
    flag <= 8'h11;
    boot_val = boot_val + 8'h01;
    boot <= boot_val;
    start_i <= 1'b1;
    @(posedge ref_clk_i);
    flag <= 8'h00;
    boot <= ~boot_val;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    repeat (6000) begin
      @(posedge ref_clk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    if (done_o !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: no completion", $time);
      results();
    end
  endtask

  task automatic check(input row_s r);
    cmp_res(result_o, r.res);
    cmp_val({40'h0, status_code_o}, {40'h0, r.code});
    if (r.res == RES_NORMAL)
      cmp_val(data_seen, {24'hA5005A, 8'h00, boot_val, 8'hF9});
  endtask

  // Reset values, the table, then a reset in the middle of a transaction.
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    cmp_val({44'h0, busy_o, done_o, tx_valid_o, rx_enable_o}, 48'h0);
    cmp_res(result_o, RES_NONE);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      run(rows[i]);
      check(rows[i]);
      $display("test %0d finished", i);
    end
    @(posedge ref_clk_i);
    mute <= 2'd1;
    start_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    start_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    #1;
    cmp_val({44'h0, busy_o, done_o, tx_valid_o, rx_enable_o}, 48'h0);
    cmp_res(result_o, RES_NONE);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    run(rows[0]);
    check(rows[0]);
    $display("reset test finished");
    results();
  end
endmodule

bind security_set_host secset_properties #(
  .CMD_WAIT_CYCLES(CMD_WAIT_CYCLES)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
  .status_code_o(status_code_o), .tx_valid_o(tx_valid_o),
  .tx_frame_o(tx_frame_o), .tx_ready_i(tx_ready_i),
  .rx_enable_o(rx_enable_o), .rx_valid_i(rx_valid_i),
  .rx_status_i(rx_status_i));
